// ===== frcc_pkg.sv
/*
 Package for the free-running capture/compare timer: prescaler selects,
 edge modes, widths and reset values.
 Assumes nothing of its surroundings.
*/
package frcc_pkg;
	localparam int COUNT_W = 16;
	localparam int N_CAPTURE = 2;
	localparam int N_COMPARE = 4;
	localparam int PRESC_W = 6;
	// Prescale select codes: machine clock /4, /16, /32, /64
	typedef enum logic [1:0] {
		FRCC_DIV4,
		FRCC_DIV16,
		FRCC_DIV32,
		FRCC_DIV64
	} frcc_div_t;
	localparam logic [PRESC_W-1:0] DIV4_LAST = 6'h03;
	localparam logic [PRESC_W-1:0] DIV16_LAST = 6'h0F;
	localparam logic [PRESC_W-1:0] DIV32_LAST = 6'h1F;
	localparam logic [PRESC_W-1:0] DIV64_LAST = 6'h3F;
	// Capture edge select codes
	typedef enum logic [1:0] {
		FRCC_EDGE_NONE,
		FRCC_EDGE_RISE,
		FRCC_EDGE_FALL,
		FRCC_EDGE_BOTH
	} frcc_edge_t;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
	localparam logic [COUNT_W-1:0] COUNT_ALL_ONES = 16'hFFFF;
	localparam logic [PRESC_W-1:0] PRESC_RESET = 6'h00;
endpackage : frcc_pkg

// ===== frcc_timer.sv
/*
 Free-running 16-bit capture/compare timer: prescaled up counter shared by
 two edge-capture channels and four time-multiplexed compare channels.
 Assumes control bits come as plain synchronous ports from the CPU side and
 that the interrupt controller takes one-cycle request pulses.
 Assumes the capture pins are already synchronous to the machine clock; a
 pin that is high at reset release gives no false edge, since the previous
 level register follows the pin during reset.
 Assumes the transfer service logic takes a one-cycle request per capture.
 The compare scan visits each channel once per N_CMP cycles, so a compare
 value is only seen if the count holds it for at least N_CMP cycles; the
 slowest scan of four channels is met by every division from /4 upward, save the zero after a compare-0 clear, cut short by the running prescaler.
 A compare channel matches at most once per counter value; it is re-armed
 only when the counter takes a different value.
 Soft clear wins over every other counter action.
 The overflow request and the compare-0 request share one timer pulse.
*/
// Behaviour
// R01 - 16-bit up counter, clock /4 /16 /32 /64
// R02 - Overflow, or optional compare-0 match, raises interrupt
// R03 - Reset, soft clear, compare-0 match zero counter
// R04 - One counter feeds every channel
// R05 - Valid edge stores count, optionally interrupts
// R06 - Edge select: rising, falling or both
// R07 - Two capture pins, each own register
// R08 - Capture may request auto transfer service
// R09 - Two capture and four compare channels
// R10 - One shared comparator scans compare registers
// R11 - Output toggles on match or drives level bit
// R12 - Counter wraps all-ones to zero, keeps counting
`timescale 1ns/10ps
module frcc_timer #(
	parameter int N_CAP = frcc_pkg::N_CAPTURE,
	parameter int N_CMP = frcc_pkg::N_COMPARE
) (
	input  wire logic                                  i_sys_clk,
	input  wire logic                                  i_rst,
	input  wire logic [1:0]                            i_div_sel,
	input  wire logic                                  i_soft_clear,
	input  wire logic                                  i_match0_clear_en,
	input  wire logic                                  i_ovf_irq_en,
	input  wire logic                                  i_match0_irq_en,
	input  wire logic [N_CAP-1:0]                      i_capture_pin,
	input  wire logic [N_CAP*2-1:0]                    i_edge_sel,
	input  wire logic [N_CAP-1:0]                      i_cap_irq_en,
	input  wire logic [N_CAP-1:0]                      i_cap_xfer_en,
	input  wire logic [N_CMP*frcc_pkg::COUNT_W-1:0]    i_compare_value,
	input  wire logic [N_CMP-1:0]                      i_cmp_irq_en,
	input  wire logic [N_CMP-1:0]                      i_toggle_mode,
	input  wire logic [N_CMP-1:0]                      i_direct_output_level_bit,
	output logic      [frcc_pkg::COUNT_W-1:0]          o_count,
	output logic                                       o_timer_irq,
	output logic [N_CAP*frcc_pkg::COUNT_W-1:0]         o_captured_count_register,
	output logic      [N_CAP-1:0]                      o_cap_irq,
	output logic      [N_CAP-1:0]                      o_auto_transfer_service,
	output logic      [N_CMP-1:0]                      o_cmp_irq,
	output logic      [N_CMP-1:0]                      o_wave_out
);
	localparam int CW = frcc_pkg::COUNT_W;
	localparam int SEL_W = (N_CMP > 1) ? $clog2(N_CMP) : 1;

	// Elaboration check on channel counts
	if (N_CAP != 2 || N_CMP < 1 || N_CMP > 4) begin : g_bad_param
		$error("frcc_timer: two capture and one to four compare channels");
	end

	// Prescaler must hold the slowest terminal count
	if (frcc_pkg::PRESC_W < 6) begin : g_bad_presc
		$error("frcc_timer: prescaler too narrow for the slowest division");
	end

	// Counter must be wide enough to be a useful time base
	if (CW < 2) begin : g_bad_count
		$error("frcc_timer: counter width too small");
	end

	////////////////////////////////////////////////////////////////////////////
	// Prescaler and free-running counter
	logic [frcc_pkg::PRESC_W-1:0] presc;
	logic [frcc_pkg::PRESC_W-1:0] presc_last;
	logic [frcc_pkg::PRESC_W-1:0] next_presc;
	logic [CW-1:0]                next_count;
	logic                         next_timer_irq;
	logic                         tick;
	logic                         clear_req;
	logic                         count_moves;
	logic                         match0_hit;
	logic                         overflow;

	// Terminal count for the chosen division
	always_comb begin
		unique case (frcc_pkg::frcc_div_t'(i_div_sel))
			frcc_pkg::FRCC_DIV4:  presc_last = frcc_pkg::DIV4_LAST;
			frcc_pkg::FRCC_DIV16: presc_last = frcc_pkg::DIV16_LAST;
			frcc_pkg::FRCC_DIV32: presc_last = frcc_pkg::DIV32_LAST;
			frcc_pkg::FRCC_DIV64: presc_last = frcc_pkg::DIV64_LAST;
		endcase
	end
	// Step strobe; also fires at once if a slower division left the prescaler at or past the new terminal count
	assign tick = (presc >= presc_last); // R01
	assign overflow = tick && (o_count == frcc_pkg::COUNT_ALL_ONES); // R12

	// Counter clear sources
	assign clear_req = i_soft_clear || (match0_hit && i_match0_clear_en); // R03

	// Counter takes a new value at this edge
	assign count_moves = (next_count != o_count);

	// Next prescaler value
	always_comb begin
		if (i_soft_clear || tick) begin
			next_presc = frcc_pkg::PRESC_RESET; // R01
		end else begin
			next_presc = presc + 1'b1;
		end
	end

	// Prescaler divides the machine clock
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			presc <= frcc_pkg::PRESC_RESET;
		end else begin
			presc <= next_presc;
		end
	end

	// Next count: clear first, then the prescaled step
	always_comb begin
		if (clear_req) begin
			next_count = frcc_pkg::COUNT_RESET; // R03
		end else if (tick) begin
			next_count = o_count + 1'b1; // R01 R12
		end else begin
			next_count = o_count;
		end
	end

	// Counter register, wraps naturally on overflow
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_count <= frcc_pkg::COUNT_RESET; // R03
		end else begin
			o_count <= next_count;
		end
	end

	// Timer request from overflow or compare-0 match
	always_comb begin
		next_timer_irq = 1'b0;
		if (overflow && i_ovf_irq_en) begin
			next_timer_irq = 1'b1; // R02
		end
		if (match0_hit && i_match0_irq_en) begin
			next_timer_irq = 1'b1; // R02
		end
	end

	// Timer interrupt pulse
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_timer_irq <= 1'b0;
		end else begin
			o_timer_irq <= next_timer_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Edge capture unit
	logic [N_CAP-1:0] pin_prev;

	// Previous pin level; tracks the pin in reset so no false edge follows
	always_ff @(posedge i_sys_clk) begin
		pin_prev <= i_capture_pin;
	end

	for (genvar c = 0; c < N_CAP; c++) begin : g_cap // R07 R09
		logic                 rise;
		logic                 fall;
		logic                 hit;
		logic [CW-1:0]        cap_value;
		logic                 cap_irq;
		logic                 cap_xfer;
		frcc_pkg::frcc_edge_t mode;

		// Mode and raw edges of this pin
		assign mode = frcc_pkg::frcc_edge_t'(i_edge_sel[c*2 +: 2]);
		assign rise = i_capture_pin[c] && !pin_prev[c];
		assign fall = !i_capture_pin[c] && pin_prev[c];
		// Edge qualification per mode
		always_comb begin
			unique case (mode)
				frcc_pkg::FRCC_EDGE_NONE: hit = 1'b0;
				frcc_pkg::FRCC_EDGE_RISE: hit = rise; // R06
				frcc_pkg::FRCC_EDGE_FALL: hit = fall; // R06
				frcc_pkg::FRCC_EDGE_BOTH: hit = rise || fall; // R06
			endcase
		end
		// Latch the shared count, held until the next valid edge
		always_ff @(posedge i_sys_clk) begin
			if (i_rst) begin
				cap_value <= frcc_pkg::COUNT_RESET;
			end else if (hit) begin
				cap_value <= o_count; // R04 R05
			end
		end

		// Interrupt and transfer requests, same edge as the latch
		always_ff @(posedge i_sys_clk) begin
			if (i_rst) begin
				cap_irq  <= 1'b0;
				cap_xfer <= 1'b0;
			end else begin
				cap_irq  <= hit && i_cap_irq_en[c]; // R05
				cap_xfer <= hit && i_cap_xfer_en[c]; // R08
			end
		end

		// Channel slices of the output ports
		assign o_captured_count_register[c*CW +: CW] = cap_value;
		assign o_cap_irq[c]                          = cap_irq;
		assign o_auto_transfer_service[c]            = cap_xfer;
	end

	////////////////////////////////////////////////////////////////////////////
	// Match compare unit: one comparator visits each channel in turn
	logic [SEL_W-1:0] scan;
	logic [SEL_W-1:0] next_scan;
	logic [CW-1:0]    scan_value;
	logic             scan_eq;
	logic [N_CMP-1:0] matched;

	// Next channel in round-robin order
	always_comb begin
		if (scan == SEL_W'(N_CMP - 1)) begin
			next_scan = '0;
		end else begin
			next_scan = scan + 1'b1; // R10
		end
	end

	// Round-robin channel pointer
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			scan <= '0;
		end else begin
			scan <= next_scan;
		end
	end

	// The single comparator
	assign scan_value = i_compare_value[scan*CW +: CW];
	assign scan_eq = (scan_value == o_count); // R10 R04

	// One match per counter value per channel
	for (genvar k = 0; k < N_CMP; k++) begin : g_cmp // R09
		logic armed;
		logic hit;
		logic irq;
		logic wave;

		// Hit on this channel's turn, if not yet used at this value
		assign hit = scan_eq && (scan == SEL_W'(k)) && armed; // R10
		assign matched[k] = hit;

		// Re-armed whenever the counter takes a new value
		always_ff @(posedge i_sys_clk) begin
			if (i_rst) begin
				armed <= 1'b1;
			end else if (count_moves) begin
				armed <= 1'b1;
			end else if (hit) begin
				armed <= 1'b0;
			end
		end

		// Match request, one cycle
		always_ff @(posedge i_sys_clk) begin
			if (i_rst) begin
				irq <= 1'b0;
			end else begin
				irq <= hit && i_cmp_irq_en[k]; // R10
			end
		end

		// Waveform pin: toggle on match or follow the level bit
		always_ff @(posedge i_sys_clk) begin
			if (i_rst) begin
				wave <= 1'b0;
			end else if (!i_toggle_mode[k]) begin
				wave <= i_direct_output_level_bit[k]; // R11
			end else if (hit) begin
				wave <= !wave; // R11
			end
		end

		// Channel bits of the output ports
		assign o_cmp_irq[k]  = irq;
		assign o_wave_out[k] = wave;
	end

	// Channel 0 also drives the counter clear and timer request
	assign match0_hit = matched[0]; // R02 R03
endmodule : frcc_timer

// ===== frcc_props.sv
/* Checker for frcc_timer: counter, capture, timer irq, waveform pins.
 Assumes it sees only the timer's ports. */
`timescale 1ns/10ps
module frcc_props #(
	parameter int N_CAP = 2,
	parameter int N_CMP = 4
) (
	input wire logic                i_sys_clk,
	input wire logic                i_rst,
	input wire logic                i_soft_clear,
	input wire logic                i_match0_clear_en,
	input wire logic                i_ovf_irq_en,
	input wire logic                i_match0_irq_en,
	input wire logic [N_CAP-1:0]    i_capture_pin,
	input wire logic [N_CAP*2-1:0]  i_edge_sel,
	input wire logic [N_CAP-1:0]    i_cap_irq_en,
	input wire logic [N_CMP*16-1:0] i_compare_value,
	input wire logic [N_CMP-1:0]    i_toggle_mode,
	input wire logic [15:0]         o_count,
	input wire logic                o_timer_irq,
	input wire logic [N_CAP*16-1:0] o_captured_count_register,
	input wire logic [N_CAP-1:0]    o_cap_irq,
	input wire logic [N_CMP-1:0]    o_wave_out
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	////////////////////////////////////////////////////////////////////////
	// Capture pulse, stored value, edge filter
	AST_CAP_IRQ: assert property (
		$rose(i_capture_pin[0]) && i_edge_sel[0] && i_cap_irq_en[0] |-> ##[1:2] o_cap_irq[0])
		else $error("rise not captured");
	AST_CAP_VAL: assert property (
		o_cap_irq[0] |-> o_captured_count_register[15:0] == $past(o_count)
		|| o_captured_count_register[15:0] == $past(o_count, 2)) else $error("bad capture");
	AST_FALL_ONLY: assert property (
		$rose(i_capture_pin[1]) && i_edge_sel[3:2] == 2'h2 |=> !o_cap_irq[1] [*2])
		else $error("rise captured in fall mode");
	// Counter steps, spacing, wrap and timer irq
	AST_CNT_STEP: assert property (
		$changed(o_count) |-> o_count == $past(o_count) + 16'h0001 || o_count == 16'h0000)
		else $error("counter jump");
	AST_CNT_HOLD: assert property (
		$changed(o_count) && o_count != 16'h0000 |=> ($stable(o_count) || o_count == 16'h0000) [*3])
		else $error("count faster than /4");
	AST_TIRQ_OFF: assert property (
		!i_ovf_irq_en && !i_match0_irq_en && !$past(i_ovf_irq_en) && !$past(i_match0_irq_en)
		|-> !o_timer_irq) else $error("timer irq while disabled");
	AST_OVF: assert property (
		$past(o_count) == 16'hFFFF && o_count == 16'h0000 && $past(i_ovf_irq_en)
		&& !$past(i_soft_clear) && !($past(i_match0_clear_en)
		&& i_compare_value[15:0] == 16'hFFFF) |-> ##[0:1] o_timer_irq)
		else $error("overflow irq missing");
	AST_TOGGLE: assert property (
		$changed(o_wave_out[1]) && i_toggle_mode[1] && $past(i_toggle_mode[1])
		|-> $past(o_count) == i_compare_value[31:16] || $past(o_count, 2) == i_compare_value[31:16])
		else $error("toggle without match");
	cover property (o_cap_irq[1]);
	cover property (o_timer_irq);
	cover property ($changed(o_wave_out[1]));
endmodule : frcc_props
bind frcc_timer frcc_props #(.N_CAP(N_CAP), .N_CMP(N_CMP)) u_props (.*);

// ===== frcc_pin_src.sv
/* Pulse source on the capture pins.
 Assumes requests change at the falling clock edge. */
`timescale 1ns/10ps
module frcc_pin_src (
	input  wire logic       i_sys_clk,
	input  wire logic [1:0] i_want,
	output logic      [1:0] o_pin
);
	logic [1:0] held = 2'h0;
	// Pins follow requests a cycle later, at a falling edge
	initial o_pin = 2'h0;
	always @(posedge i_sys_clk) held <= i_want;
	always @(negedge i_sys_clk) o_pin <= held;
endmodule : frcc_pin_src

// ===== frcc_timer_tb_top.sv
/* Bench for frcc_timer: edge captures, compare clear, waveform pins.
 Assumes frcc_pin_src drives the capture pins. */
`timescale 1ns/10ps
module frcc_timer_tb_top;
	logic        i_sys_clk, i_rst, i_soft_clear, i_match0_clear_en, i_ovf_irq_en;
	logic        i_match0_irq_en, o_timer_irq, w;
	logic [1:0]  i_div_sel, i_capture_pin, i_cap_irq_en, i_cap_xfer_en;
	logic [1:0]  o_cap_irq, o_auto_transfer_service, want;
	logic [3:0]  i_edge_sel, i_cmp_irq_en, i_toggle_mode, i_direct_output_level_bit;
	logic [3:0]  o_cmp_irq, o_wave_out, lvl;
	logic [15:0] o_count;
	logic [31:0] o_captured_count_register;
	logic [63:0] i_compare_value;
	logic [16:0] q[$], e;
	int          cyc, miscompares, n_tests, seed, t, n;
	frcc_timer dut (.i_sys_clk, .i_rst, .i_div_sel, .i_soft_clear, .i_match0_clear_en,
		.i_ovf_irq_en, .i_match0_irq_en, .i_capture_pin, .i_edge_sel, .i_cap_irq_en,
		.i_cap_xfer_en, .i_compare_value, .i_cmp_irq_en, .i_toggle_mode,
		.i_direct_output_level_bit, .o_count, .o_timer_irq, .o_captured_count_register,
		.o_cap_irq, .o_auto_transfer_service, .o_cmp_irq, .o_wave_out);
	frcc_pin_src src (.i_sys_clk, .i_want(want), .o_pin(i_capture_pin));
	task chk(input logic [16:0] exp, input logic [16:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk
	task wt(input int b);
		n = 0;
		@(negedge i_sys_clk);
		while ({o_timer_irq, o_cmp_irq} >> b != 5'h1 && n < 99) begin
			@(negedge i_sys_clk);
			n++;
		end
		if (n == 99) miscompares++;
	endtask : wt
	task wrap_up;
		$display("checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////
	// Clock, cycles since release, watchdog
	initial begin
		i_sys_clk = 1'b0;
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) cyc <= i_rst ? 0 : cyc + 1;
	initial begin
		#25000;
		miscompares++;
		wrap_up;
	end
	// Oldest capture note against each capture pulse
	always @(negedge i_sys_clk) if (!i_rst && o_cap_irq !== 2'h0) begin
		e = q.size() ? q.pop_front() : 17'h1FFFF;
		chk(e, {o_cap_irq[1], o_captured_count_register[o_cap_irq[1]*16 +: 16]});
		chk(17'({2{e[16] ? 2'h2 : 2'h1}}), 17'({o_auto_transfer_service, o_cap_irq}));
	end
	// Stimulus: captures at /64, then compare clear and waveforms at /4
	initial begin
		seed = 32'h0B7A8102;
		{i_rst, i_soft_clear, i_match0_clear_en, i_ovf_irq_en, i_match0_irq_en} = 5'h10;
		{i_div_sel, want, i_cap_irq_en, i_cap_xfer_en} = 8'hCF;
		{i_edge_sel, i_cmp_irq_en, i_toggle_mode, i_direct_output_level_bit} = 16'h0F00;
		i_compare_value = 64'h0003_0007;
		repeat (20) @(negedge i_sys_clk);
		i_rst = 1'b0;
		for (t = 0; t < 16; t++) begin
			while (cyc % 64 != 30) @(negedge i_sys_clk);
			i_edge_sel = {2{t[3:2]}};
			want[t%2] = ~want[t%2];
			if (want[t%2] ? t[2] : t[3]) q.push_back({t[0], 16'(cyc / 64)});
			@(negedge i_sys_clk);
		end
		repeat (4) @(negedge i_sys_clk);
		$display("capture test done");
		{i_div_sel, i_toggle_mode} = 6'h02;
		{i_match0_clear_en, i_match0_irq_en, i_ovf_irq_en, i_soft_clear} = 4'hF;
		@(negedge i_sys_clk);
		i_soft_clear = 1'b0;
		chk(17'h0, 17'(o_count));
		for (t = 0; t < 4; t++) begin
			w = o_wave_out[1];
			lvl = 4'($random(seed));
			i_direct_output_level_bit = lvl;
			wt(1);
			wt(4);
			chk(17'h0, 17'(o_count));
			chk({w, lvl[2]}, {~o_wave_out[1], o_wave_out[2]});
		end
		$display("compare test done");
		if (q.size() != 0) miscompares++;
		wrap_up;
	end
endmodule : frcc_timer_tb_top
